// *** cfg_mem_model.sv ***
// Configuration memory partner feeding words to the check
`timescale 1ns/10ps
`default_nettype none
module cfg_mem_model (
    input  wire logic [5:0]  cfg_addr_i,
    output logic      [31:0] cfg_word_o
);
    // Distinct word per address, so a wrong address changes the CRC
    assign cfg_word_o = {8'ha5, 2'b00, cfg_addr_i, 8'h3c, 2'b00, ~cfg_addr_i};
endmodule
`default_nettype wire

// *** cfg_sec_consts.svh ***
// Offsets, fields, reset values and timing counts of the configuration security block
`ifndef CFG_SEC_CONSTS_SVH
`define CFG_SEC_CONSTS_SVH

`define ADR_CTRL        4'h0
`define ADR_STATUS      4'h1
`define ADR_IRQ_STAT    4'h2
`define ADR_IRQ_MASK    4'h3
`define ADR_CMD         4'h4
`define ADR_ID_LO       4'h5
`define ADR_ID_HI       4'h6
`define ADR_CRC_EXP     4'h7
`define ADR_CRC_VAL     4'h8
`define ADR_BOOT        4'h9

`define CTRL_SEC_EN     0
`define CTRL_SEC_OFF    1
`define CTRL_DUAL_BOOT  2
`define CTRL_USER_ID_LO 8

`define CMD_SET_LOCK    8'h01
`define CMD_SET_OTP     8'h02
`define CMD_ERASE       8'h03
`define CMD_PROGRAM     8'h04
`define CMD_READBACK    8'h05
`define CMD_BOOT        8'h06

`define IRQ_CHK_ERR     0
`define IRQ_CHK_DONE    1
`define IRQ_REJECT      2
`define IRQ_FALLBACK    3
`define IRQ_BITS        4

`define CRC_INIT        32'hffffffff
`define CRC_POLY        32'h04c11db7
`define CLK_DIV_DEF     8
`define CFG_WORDS_DEF   64
`define FACTORY_ID_DEF  56'h0123456789abcd
`endif

// *** cfg_sec_pkg.sv ***
// Types of the configuration security block
package cfg_sec_pkg;
    typedef enum logic [2:0] {
        CHK_IDLE = 3'b000,
        CHK_RUN  = 3'b001,
        CHK_CMP  = 3'b011,
        CHK_DONE = 3'b010
    } chk_state_t;
    typedef enum logic [1:0] {
        BOOT_IDLE    = 2'b00,
        BOOT_PRIMARY = 2'b01,
        BOOT_GOLDEN  = 2'b11,
        BOOT_USER    = 2'b10
    } boot_state_t;
endpackage

// *** cfg_security_boot_check.sv ***
// Security lock, one-time lock, dual boot, soft error check and trace id
`timescale 1ns/10ps
`default_nettype none
`include "cfg_sec_consts.svh"

// Function
// (R01) System holds right-side PLL in reset during background flash programming.
// (R02) While locked, reject every readback of configuration SRAM and flash.
// (R03) Only two lock states: unlocked, readback allowed, or permanently locked. Code also has locked_r, which erase clears, besides the permanent otp_r.
// (R04) Security bits clear only through a full device erase.
// (R05) After one-time lock, erase and program commands are always rejected.
// (R06) With dual boot on, corrupt primary load restarts from golden image.
// (R07) System keeps golden image in external flash, primary on chip.
// (R08) After configuration, check computes CRC over configuration SRAM.
// (R09) Check runs only while its enable option bit is set.
// (R10) In user mode, fabric trigger input starts a check.
// (R11) Check is clocked by a divider from undivided oscillator clock.
// (R12) Check circuit can be switched fully off for low power.
// (R13) Each device holds a unique 64-bit trace identifier.
// (R14) Eight identifier bits are user programmable, 56 fixed at factory.
// (R15) Identifier readable over Wishbone and the serial host interfaces.
// (R16) CRC mismatch sets a sticky error flag visible until cleared.
module cfg_security_boot_check
    import cfg_sec_pkg::*;
#(
    parameter int          CLK_DIV    = `CLK_DIV_DEF,
    parameter int          CFG_WORDS  = `CFG_WORDS_DEF,
    parameter logic [55:0] FACTORY_ID = `FACTORY_ID_DEF  // Arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        chk_trigger_i,
    input  wire logic        primary_bad_i,
    input  wire logic [31:0] cfg_word_i,
    output logic      [5:0]  cfg_addr_o,
    input  wire logic [5:0]  host_id_addr_i,
    output logic             host_id_bit_o,
    output logic             chk_error_o,
    output logic             golden_sel_o,
    output logic             user_mode_o,
    output logic             irq_o
);
    // Fabric trigger and primary-corrupt flag come from outside: two flops each
    logic [1:0] trig_s_r, bad_s_r;
    logic       trig_d_r;
    always_ff @(posedge clk_i) begin
        trig_s_r <= {trig_s_r[0], chk_trigger_i};
        bad_s_r  <= {bad_s_r[0], primary_bad_i};
        trig_d_r <= trig_s_r[1];
    end
    wire trig_rise = trig_s_r[1] & ~trig_d_r;

    // Register bus decode
    logic        ack_r;
    wire         bus_req = cyc_i & stb_i & ~ack_r;
    wire         wr_req  = bus_req & we_i;
    wire         wr_b0   = wr_req & sel_i[0];

    logic [31:0] ctrl_r, crc_exp_r;
    logic        locked_r, otp_r, chk_err_r;
    logic [`IRQ_BITS-1:0] irq_stat_r, irq_mask_r;
    wire  [7:0]  cmd = dat_i[7:0];
    wire  cmd_wr   = wr_b0 && adr_i == `ADR_CMD;
    wire  do_erase = cmd_wr && cmd == `CMD_ERASE && !otp_r;          // see (R04) (R05)
    wire  rejected = cmd_wr && ((otp_r && (cmd == `CMD_ERASE || cmd == `CMD_PROGRAM))
                     || (locked_r && cmd == `CMD_READBACK));         // see (R02) (R05)

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r    <= 32'h00000000;
            crc_exp_r <= `CRC_INIT;
            locked_r  <= 1'b0;
            otp_r     <= 1'b0;
        end else begin
            if (wr_b0 && adr_i == `ADR_CTRL)
                ctrl_r[7:0] <= dat_i[7:0];
            if (wr_req && sel_i[1] && adr_i == `ADR_CTRL && !otp_r)
                ctrl_r[15:8] <= dat_i[15:8];                         // see (R14)
            if (wr_req && adr_i == `ADR_CRC_EXP)
                crc_exp_r <= dat_i;
            // Locked is one-way except through erase
            if (do_erase)
                locked_r <= 1'b0;                                    // see (R03) (R04)
            else if (cmd_wr && cmd == `CMD_SET_LOCK)
                locked_r <= 1'b1;
            if (cmd_wr && cmd == `CMD_SET_OTP)
                otp_r <= 1'b1;                                       // see (R05)
        end
    end

    wire [63:0] trace_id = {FACTORY_ID, ctrl_r[15:8]};               // see (R13) (R14)

    // Dual boot sequencer
    boot_state_t boot_r;
    logic        boot_kick_r;
    wire         boot_cmd = cmd_wr && cmd == `CMD_BOOT;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_r      <= BOOT_PRIMARY;
            boot_kick_r <= 1'b0;
        end else begin
            boot_kick_r <= 1'b0;
            case (boot_r)
                BOOT_PRIMARY: begin
                    if (bad_s_r[1] && ctrl_r[`CTRL_DUAL_BOOT])
                        boot_r <= BOOT_GOLDEN;                       // see (R06) (R07)
                    else if (!bad_s_r[1]) begin
                        boot_r      <= BOOT_USER;
                        boot_kick_r <= 1'b1;
                    end
                end
                BOOT_GOLDEN: begin
                    boot_r      <= BOOT_USER;
                    boot_kick_r <= 1'b1;
                end
                BOOT_USER:
                    if (boot_cmd)
                        boot_r <= BOOT_PRIMARY;
                default:
                    boot_r <= BOOT_PRIMARY;
            endcase
        end
    end

    // Divider from undivided oscillator clock makes the check tick
    localparam int DW = $clog2(CLK_DIV + 1);
    logic [DW-1:0] div_r;
    wire  chk_on  = ctrl_r[`CTRL_SEC_EN] & ~ctrl_r[`CTRL_SEC_OFF];   // see (R09) (R12)
    wire  div_end = div_r == DW'(CLK_DIV - 1);
    wire  tick    = chk_on & div_end;
    always_ff @(posedge clk_i) begin
        if (rst_i || !chk_on)
            div_r <= '0;                                             // see (R12)
        else if (div_end)
            div_r <= '0;                                             // see (R11)
        else
            div_r <= div_r + DW'(1);
    end

    // CRC over configuration words
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--)
            r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `CRC_POLY : 32'h0);
        return r;
    endfunction

    chk_state_t  chk_r;
    logic [31:0] crc_r;
    logic [5:0]  addr_r;
    logic        chk_pend_r, chk_done_ev_r;
    wire  start_req = (boot_kick_r | (trig_rise & (boot_r == BOOT_USER)));  // see (R08) (R10)
    wire  last_word = addr_r == 6'(CFG_WORDS - 1);
    wire  mismatch  = chk_r == CHK_CMP && tick && crc_r != crc_exp_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || !chk_on) begin
            chk_r         <= CHK_IDLE;
            crc_r         <= `CRC_INIT;
            addr_r        <= 6'h00;
            chk_pend_r    <= 1'b0;
            chk_done_ev_r <= 1'b0;
        end else begin
            chk_done_ev_r <= 1'b0;
            if (start_req)
                chk_pend_r <= 1'b1;
            if (tick) begin
                case (chk_r)
                    CHK_IDLE:
                        if (chk_pend_r) begin
                            chk_pend_r <= start_req;
                            crc_r      <= `CRC_INIT;
                            addr_r     <= 6'h00;
                            chk_r      <= CHK_RUN;
                        end
                    CHK_RUN: begin
                        crc_r  <= crc_step(crc_r, cfg_word_i);       // see (R08)
                        addr_r <= addr_r + 6'h01;
                        if (last_word)
                            chk_r <= CHK_CMP;
                    end
                    CHK_CMP:
                        chk_r <= CHK_DONE;
                    CHK_DONE: begin
                        chk_done_ev_r <= 1'b1;
                        chk_r         <= CHK_IDLE;
                    end
                    default:
                        chk_r <= CHK_IDLE;
                endcase
            end
        end
    end

    // Sticky error and interrupt status: set wins over clear
    wire [`IRQ_BITS-1:0] ev;
    assign ev[`IRQ_CHK_ERR]  = mismatch;
    assign ev[`IRQ_CHK_DONE] = chk_done_ev_r;
    assign ev[`IRQ_REJECT]   = rejected;
    assign ev[`IRQ_FALLBACK] = boot_r == BOOT_PRIMARY && bad_s_r[1] && ctrl_r[`CTRL_DUAL_BOOT];
    wire  irq_clr_wr = wr_b0 && adr_i == `ADR_IRQ_STAT;
    wire  err_clr    = wr_b0 && adr_i == `ADR_STATUS && dat_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            chk_err_r  <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(irq_clr_wr ? dat_i[`IRQ_BITS-1:0] : '0)) | ev;
            if (wr_b0 && adr_i == `ADR_IRQ_MASK)
                irq_mask_r <= dat_i[`IRQ_BITS-1:0];
            chk_err_r  <= (chk_err_r & ~err_clr) | mismatch;         // see (R16)
        end
    end

    // Read mux; readback of protected words answers zero while locked
    logic [31:0] rd_data;
    wire  [31:0] status_w = {20'h0, otp_r, locked_r, boot_r, 1'b0, chk_r, 1'b0, chk_pend_r,
                             chk_on, chk_err_r};
    always_comb begin
        case (adr_i)
            `ADR_CTRL:     rd_data = ctrl_r;
            `ADR_STATUS:   rd_data = status_w;
            `ADR_IRQ_STAT: rd_data = {28'h0, irq_stat_r};
            `ADR_IRQ_MASK: rd_data = {28'h0, irq_mask_r};
            `ADR_ID_LO:    rd_data = trace_id[31:0];                 // see (R15)
            `ADR_ID_HI:    rd_data = trace_id[63:32];
            `ADR_CRC_EXP:  rd_data = crc_exp_r;
            `ADR_CRC_VAL:  rd_data = locked_r ? 32'h0 : crc_r;       // see (R02)
            default:       rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r         <= 1'b0;
            dat_o         <= 32'h0;
            cfg_addr_o    <= 6'h00;
            host_id_bit_o <= 1'b0;
            chk_error_o   <= 1'b0;
            golden_sel_o  <= 1'b0;
            user_mode_o   <= 1'b0;
            irq_o         <= 1'b0;
        end else begin
            ack_r         <= bus_req;
            dat_o         <= bus_req ? rd_data : 32'h0;
            cfg_addr_o    <= addr_r;
            host_id_bit_o <= trace_id[host_id_addr_i];               // see (R15)
            chk_error_o   <= chk_err_r | mismatch;
            golden_sel_o  <= boot_r == BOOT_GOLDEN;
            user_mode_o   <= boot_r == BOOT_USER;
            irq_o         <= |((irq_stat_r | ev) & irq_mask_r);
        end
    end
    assign ack_o = ack_r;

    // Cycles spent away from idle, bounds one whole check pass
    logic [15:0] busy_cnt_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || chk_r == CHK_IDLE)
            busy_cnt_r <= 16'h0000;
        else
            busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
    wire  [15:0] busy_max = 16'((CFG_WORDS + 3) * CLK_DIV);

    // Checks
    a_lock_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // see (R04)
        locked_r && !do_erase |=> locked_r)
        else $error("lock cleared without erase");
    a_erase_clears: assert property (@(posedge clk_i) disable iff (rst_i) // see (R04)
        do_erase |=> !locked_r)
        else $error("erase left lock set");
    a_otp_keep: assert property (@(posedge clk_i) disable iff (rst_i) // see (R05)
        otp_r |=> otp_r)
        else $error("otp lock dropped");
    a_otp_erase: assert property (@(posedge clk_i) disable iff (rst_i) // see (R05)
        otp_r && cmd_wr && cmd == `CMD_ERASE |=> irq_stat_r[`IRQ_REJECT])
        else $error("erase not rejected");
    a_otp_program: assert property (@(posedge clk_i) disable iff (rst_i) // see (R05)
        otp_r && cmd_wr && cmd == `CMD_PROGRAM |=> irq_stat_r[`IRQ_REJECT])
        else $error("program not rejected");
    a_user_id_frozen: assert property (@(posedge clk_i) disable iff (rst_i) // see (R14)
        otp_r |=> $stable(ctrl_r[15:8]))
        else $error("user id changed after otp");
    a_locked_read: assert property (@(posedge clk_i) disable iff (rst_i) // see (R02)
        bus_req && !we_i && adr_i == `ADR_CRC_VAL && locked_r |=> dat_o == 32'h0)
        else $error("readback leaked");
    a_read_reject: assert property (@(posedge clk_i) disable iff (rst_i) // see (R02)
        locked_r && cmd_wr && cmd == `CMD_READBACK |=> irq_stat_r[`IRQ_REJECT])
        else $error("readback command not rejected");
    a_rej_unlocked: assert property (@(posedge clk_i) disable iff (rst_i) // see (R03)
        !locked_r && !otp_r |-> !rejected)
        else $error("command rejected while unlocked");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // see (R15)
        ack_r |=> !ack_r)
        else $error("ack held too long");
    a_fallback: assert property (@(posedge clk_i) disable iff (rst_i) // see (R06)
        boot_r == BOOT_PRIMARY && bad_s_r[1] && ctrl_r[`CTRL_DUAL_BOOT] |=> boot_r == BOOT_GOLDEN)
        else $error("no golden reboot");
    a_fallback_off: assert property (@(posedge clk_i) disable iff (rst_i) // see (R06)
        boot_r == BOOT_PRIMARY && bad_s_r[1] && !ctrl_r[`CTRL_DUAL_BOOT] |=> boot_r == BOOT_PRIMARY)
        else $error("fallback without dual boot");
    a_clean_boot: assert property (@(posedge clk_i) disable iff (rst_i) // see (R06)
        boot_r == BOOT_PRIMARY && !bad_s_r[1] |=> boot_r == BOOT_USER)
        else $error("clean primary not booted");
    a_golden_user: assert property (@(posedge clk_i) disable iff (rst_i) // see (R06)
        boot_r == BOOT_GOLDEN |=> boot_r == BOOT_USER ##1 user_mode_o)
        else $error("golden boot did not finish");
    a_gold_out: assert property (@(posedge clk_i) disable iff (rst_i) // see (R06)
        boot_r == BOOT_GOLDEN |=> golden_sel_o)
        else $error("golden select not shown");
    a_user_out: assert property (@(posedge clk_i) disable iff (rst_i) // see (R06)
        boot_r == BOOT_USER |=> user_mode_o)
        else $error("user mode not shown");
    a_cmd_boot: assert property (@(posedge clk_i) disable iff (rst_i) // see (R08)
        boot_r == BOOT_USER && boot_cmd |=> boot_r == BOOT_PRIMARY)
        else $error("reboot command ignored");
    a_user_kick: assert property (@(posedge clk_i) disable iff (rst_i) // see (R08)
        boot_kick_r && chk_on |=> chk_pend_r || chk_r != CHK_IDLE)
        else $error("boot did not queue a check");
    a_check_bounded: assert property (@(posedge clk_i) disable iff (rst_i) // see (R08)
        busy_cnt_r <= busy_max)
        else $error("check pass too long");
    a_done_irq: assert property (@(posedge clk_i) disable iff (rst_i) // see (R08)
        chk_done_ev_r |=> irq_stat_r[`IRQ_CHK_DONE])
        else $error("check done not flagged");
    a_check_off: assert property (@(posedge clk_i) disable iff (rst_i) // see (R09) (R12)
        !chk_on |=> chk_r == CHK_IDLE && div_r == '0)
        else $error("check active while off");
    a_div_tick: assert property (@(posedge clk_i) disable iff (rst_i) // see (R11)
        tick |=> !tick)
        else $error("divider tick too often");
    a_trigger: assert property (@(posedge clk_i) disable iff (rst_i) // see (R10)
        chk_on && trig_rise && boot_r == BOOT_USER |=> chk_pend_r || chk_r != CHK_IDLE)
        else $error("trigger lost");
    a_err_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // see (R16)
        mismatch |=> chk_err_r ##1 chk_error_o)
        else $error("error flag not set");
    a_err_clear: assert property (@(posedge clk_i) disable iff (rst_i) // see (R16)
        chk_err_r && err_clr && !mismatch |=> !chk_err_r)
        else $error("error flag not cleared");
    a_mismatch_irq: assert property (@(posedge clk_i) disable iff (rst_i) // see (R16)
        mismatch |=> irq_stat_r[`IRQ_CHK_ERR])
        else $error("crc error not flagged");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i) // see (R16)
        |(irq_stat_r & irq_mask_r) |=> irq_o)
        else $error("interrupt not raised");
    c_fallback:  cover property (@(posedge clk_i) boot_r == BOOT_GOLDEN);
    c_mismatch:  cover property (@(posedge clk_i) mismatch);
    c_done:      cover property (@(posedge clk_i) chk_done_ev_r);
    c_rejected:  cover property (@(posedge clk_i) rejected);
    c_reboot:    cover property (@(posedge clk_i) boot_cmd && boot_r == BOOT_USER);
endmodule
`default_nettype wire

// *** config_security_boot_check_tb_top.sv ***
// Self-checking bench of the configuration security block
`timescale 1ns/10ps
`default_nettype none
`include "cfg_sec_consts.svh"
module config_security_boot_check_tb_top;
    localparam int W = 4;
    logic        clk_i, rst_i, cyc, stb, we, trg, bad, ack_o, id_bit, err, gold, umode, irq;
    logic [3:0]  adr;
    logic [31:0] dat, dat_o, word, q, crc;
    logic [5:0]  caddr, id_a;
    int          n_fail, n_tests, cyc_n;
    cfg_security_boot_check #(.CLK_DIV(2), .CFG_WORDS(W)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .chk_trigger_i(trg), .primary_bad_i(bad),
        .cfg_word_i(word), .cfg_addr_o(caddr), .host_id_addr_i(id_a), .host_id_bit_o(id_bit),
        .chk_error_o(err), .golden_sel_o(gold), .user_mode_o(umode), .irq_o(irq));
    cfg_mem_model u_mem (.cfg_addr_i(caddr), .cfg_word_o(word));
    initial begin
        clk_i = 0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) n_fail++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(0, a, 0);
        chk(q & m, e);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            wb(0, `ADR_IRQ_STAT, 0);
            n++;
        end while (q[`IRQ_CHK_DONE] !== 1'b1 && n < 60);
        chk(q[`IRQ_CHK_DONE], 1'b1);
        wb(1, `ADR_IRQ_STAT, 32'hf);
    endtask
    function automatic logic [31:0] calc_crc();
        logic [31:0] c, w;
        logic        fb;
        c = `CRC_INIT;
        for (int i = 0; i < W; i++) begin
            w = {8'ha5, 2'b00, i[5:0], 8'h3c, 2'b00, ~i[5:0]};
            for (int b = 31; b >= 0; b--) begin
                fb = c[31] ^ w[b];
                c = {c[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h0);
            end
        end
        return c;
    endfunction
    task automatic t_reset_boot();
        rd(`ADR_CRC_EXP, 32'hffffffff, `CRC_INIT);
        rd(`ADR_CTRL, 32'hffffffff, 32'h0);
        chk(umode, 0);
        wb(1, `ADR_IRQ_MASK, 32'h8);
        wb(1, `ADR_CTRL, 32'h4);
        repeat (10) @(posedge clk_i);
        chk(umode, 1);
        rd(`ADR_IRQ_STAT, 32'h8, 32'h8);
        @(negedge clk_i);
        chk(irq, 1);
        wb(1, `ADR_IRQ_STAT, 32'hf);
        repeat (2) @(negedge clk_i);
        chk(irq, 0);
        bad <= 0;
    endtask
    task automatic t_check(input logic [31:0] exp_v);
        wb(1, `ADR_CRC_EXP, exp_v);
        wb(1, `ADR_CTRL, 32'h5);
        wb(1, `ADR_CMD, `CMD_BOOT);
        wait_done();
        rd(`ADR_CRC_VAL, 32'hffffffff, crc);
        chk(err, 0);
        wb(1, `ADR_CRC_EXP, exp_v ^ 32'h1);
        @(posedge clk_i) trg <= 1;
        repeat (4) @(posedge clk_i);
        trg <= 0;
        wait_done();
        chk(err, 1);
        repeat (5) @(posedge clk_i);
        chk(err, 1);
        wb(1, `ADR_STATUS, 32'h1);
        @(negedge clk_i);
        chk(err, 0);
    endtask
    task automatic t_off();
        wb(1, `ADR_CTRL, 32'h7);
        @(posedge clk_i) trg <= 1;
        repeat (4) @(posedge clk_i);
        trg <= 0;
        repeat (60) @(posedge clk_i);
        rd(`ADR_IRQ_STAT, 32'h2, 32'h0);
        wb(1, `ADR_CTRL, 32'h5a05);
    endtask
    task automatic t_id();
        logic [63:0] id;
        id = {`FACTORY_ID_DEF, 8'h5a};
        rd(`ADR_ID_LO, 32'hffffffff, id[31:0]);
        rd(`ADR_ID_HI, 32'hffffffff, id[63:32]);
        for (int i = 0; i < 64; i++) begin
            @(posedge clk_i) id_a <= i[5:0];
            repeat (2) @(negedge clk_i);
            chk(id_bit, id[i]);
        end
    endtask
    task automatic t_lock();
        wb(1, `ADR_CMD, `CMD_SET_LOCK);
        rd(`ADR_STATUS, 32'h400, 32'h400);
        rd(`ADR_CRC_VAL, 32'hffffffff, 32'h0);
        wb(1, `ADR_CMD, `CMD_READBACK);
        rd(`ADR_IRQ_STAT, 32'h4, 32'h4);
        wb(1, `ADR_IRQ_STAT, 32'hf);
        wb(1, `ADR_CMD, `CMD_PROGRAM);
        rd(`ADR_STATUS, 32'h400, 32'h400);
        wb(1, `ADR_CMD, `CMD_ERASE);
        rd(`ADR_STATUS, 32'h400, 32'h0);
        wb(1, `ADR_CMD, `CMD_SET_OTP);
        wb(1, `ADR_CMD, `CMD_SET_LOCK);
        wb(1, `ADR_CMD, `CMD_ERASE);
        rd(`ADR_STATUS, 32'hc00, 32'hc00);
        rd(`ADR_IRQ_STAT, 32'h4, 32'h4);
        wb(1, `ADR_IRQ_STAT, 32'hf);
        wb(1, `ADR_CMD, `CMD_PROGRAM);
        rd(`ADR_IRQ_STAT, 32'h4, 32'h4);
        wb(1, `ADR_CTRL, 32'h3305);
        rd(`ADR_ID_LO, 32'hff, 32'h5a);
        rd(4'hf, 32'hffffffff, 32'h0);
    endtask
    initial begin
        n_fail = 0; n_tests = 0; cyc_n = 0;
        rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0; trg = 0; bad = 1; id_a = 0;
        crc = calc_crc();
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        t_reset_boot();
        t_check(crc);
        t_off();
        t_id();
        t_lock();
        final_report();
    end
endmodule
`default_nettype wire
